// ---- single_wire_eprom_write_crc_test.sv ----
// self-checking bench: master against a behavioural device
// assumes the package counts are the full-length ones
`timescale 1ns/100ps
module single_wire_eprom_write_crc_test;
   import swe_pkg::*;
   typedef struct packed {
      swe_req_t r;
      logic bad;
   } swe_row_t;
   logic MCLK = 1'b0, RESET_N = 1'b0, REQ_VALID = 1'b0, corrupt = 1'b0;
   logic REQ_READY, RSP_VALID, DQ_O, DQ_OE, PROG_EN, pull, dq;
   swe_req_t REQ = '0;
   swe_req_t r;
   swe_rsp_t RSP;
   int miscompares = 0, checks = 0;
   logic [15:0] a, c, t;
   // top bits set under low pull-up voltage
   swe_row_t rows [6] = '{
      '{'{SWE_OP_RESET, 8'h00, 16'h0000, 8'h00, 1'b0}, 1'b0},
      '{'{SWE_OP_WRITE_FIRST, 8'h5A, 16'h0123, 8'hA5, 1'b1}, 1'b0},
      '{'{SWE_OP_WRITE_NEXT, 8'h5A, 16'h0123, 8'h3C, 1'b0}, 1'b0},
      '{'{SWE_OP_WRITE_NEXT, 8'h5A, 16'h0124, 8'h00, 1'b0}, 1'b1},
      '{'{SWE_OP_WRITE_BYTE, 8'h00, 16'h0000, 8'hC3, 1'b0}, 1'b0},
      '{'{SWE_OP_READ_BYTE, 8'h00, 16'h0000, 8'h00, 1'b0}, 1'b0}};
   assign dq = !(DQ_OE | pull);
   swe_master DUT (.MCLK(MCLK), .RESET_N(RESET_N), .REQ_VALID(REQ_VALID),
      .REQ(REQ), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP(RSP),
      .DQ_I(dq), .DQ_O(DQ_O), .DQ_OE(DQ_OE), .PROG_EN(PROG_EN));
   swe_dev_model dev (.MCLK(MCLK), .dq(dq), .corrupt(corrupt), .pull(pull));
   initial begin
      forever #5 MCLK = ~MCLK;
   end
   // ======================================================================
   // tasks
   task automatic tick();
      @(posedge MCLK);
      #1;
   endtask
   task automatic finish_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // a request is held until taken; the answer is a one-cycle pulse
   task automatic run(input swe_req_t q);
      int i;
      tick();
      REQ = q;
      REQ_VALID = 1'b1;
      for (i = 0; i < 100 && REQ_READY !== 1'b1; i++) tick();
      if (i == 100) begin
         miscompares++;
         finish_test();
      end
      tick();
      REQ_VALID = 1'b0;
      for (i = 0; i < 600000 && RSP_VALID !== 1'b1; i++) tick();
      if (i == 600000) begin
         miscompares++;
         finish_test();
      end
   endtask
   // ======================================================================
   // main sequence
   initial begin
      repeat (5) @(posedge MCLK);
      #1;
      check({REQ_READY, RSP_VALID, DQ_OE, PROG_EN, DQ_O}, 16'h0010);
      repeat (5) @(posedge MCLK);
      #1;
      RESET_N = 1'b1;
      repeat (3) tick();
      for (int k = 0; k < 6; k++) begin
         r = rows[k].r;
         corrupt = rows[k].bad;
         run(r);
         if (r.op == SWE_OP_RESET) begin
            check(RSP.presence, 1'b1);
         end else if (r.op == SWE_OP_WRITE_BYTE) begin
            // a bare byte lands on the device's next address
            a = a + 16'h0001;
            c = dev.crc_byte(a, r.data);
            check(RSP.programmed, 1'b0);
         end else if (r.op == SWE_OP_READ_BYTE) begin
            check(RSP.rdata, {8'h00, ~c[7:0]});
            check(RSP.programmed, 1'b0);
         end else begin
            if (r.op == SWE_OP_WRITE_FIRST) begin
               a = r.addr & 16'h07FF;
               t = {8'h00, r.addr[15:8]};
               if (r.low_vpup) t[7:3] = 5'h1F;
               check({8'h00, dev.ta_rx}, t);
               c = dev.crc_byte(CRC_INIT, r.cmd);
               c = dev.crc_byte(c, a[7:0]);
               c = dev.crc_byte(c, a[15:8]);
               c = dev.crc_byte(c, r.data);
            end else begin
               a = a + 16'h0001;
               c = dev.crc_byte(a, r.data);
            end
            check(RSP.crc_calc, c);
            check(RSP.crc_rx, c ^ {15'h0000, rows[k].bad});
            check(RSP.crc_ok, !rows[k].bad);
            check(RSP.programmed, !rows[k].bad);
            check(RSP.rdata, {8'h00, ~c[15:8]});
         end
      end
      // ===================================================================
      // reset in mid-slot: the line is let go at once, then idle and ready
      tick();
      REQ = rows[2].r;
      REQ_VALID = 1'b1;
      tick();
      REQ_VALID = 1'b0;
      check({REQ_READY, DQ_OE, PROG_EN}, 16'h0002);
      repeat (100) tick();
      RESET_N = 1'b0;
      #1;
      check({REQ_READY, RSP_VALID, DQ_OE, PROG_EN, DQ_O}, 16'h0010);
      repeat (2) tick();
      RESET_N = 1'b1;
      repeat (3) tick();
      check({REQ_READY, RSP_VALID, DQ_OE, PROG_EN, DQ_O}, 16'h0010);
      finish_test();
   end
endmodule

// ---- swe_crc16.sv ----
// one-byte lsb-first crc16 step (x16+x15+x2+1, reflected)
// assumes: pure combinational, used by the write-flow master
`timescale 1ns/100ps
module swe_crc16
   import swe_pkg::*;
(
   // crc in and out
   input wire logic [15:0] crc_in,
   input wire logic [7:0] data_in,
   output logic [15:0] crc_out
);
   logic [15:0] stage [0:8];
   assign stage[0] = crc_in;
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         logic fb;
         assign fb = stage[i][0] ^ data_in[i];
         assign stage[i+1] = (stage[i] >> 1) ^ (fb ? CRC_POLY : 16'h0000);
      end
   endgenerate
   assign crc_out = stage[8];
endmodule

// ---- swe_dev_model.sv ----
// behavioural eprom device for the write flow
// assumes dq is the resolved line, pulled up when nobody pulls
`timescale 1ns/100ps
module swe_dev_model
   import swe_pkg::*;
(
   // clock and line
   input wire logic MCLK,
   input wire logic dq,
   input wire logic corrupt,
   output logic pull = 1'b0
);
   // read bits held the minimum 15 us, so a late sample reads the pull-up
   localparam int H = 15 * CLK_MHZ;
   localparam int S = 30 * CLK_MHZ;
   int lo = 0, pt = 99999, st = -1, n = 0, nw = 32;
   logic dq_q = 1'b1;
   logic rd;
   logic [15:0] crc = 16'h0000, adr = 16'h0000, o;
   logic [31:0] sh = 32'h00000000;
   logic [7:0] ta_rx = 8'h00;
   function automatic logic [15:0] crc_byte(input logic [15:0] c,
      input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         c = (c[0] ^ d[i]) ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   // ======================================================================
   // slot timing from each falling edge
   always @(posedge MCLK) begin
      if (dq && !dq_q && lo >= C_RESET_LOW) begin
         pt = 0;
         n = 0;
         nw = 32;
         st = -1;
      end
      lo = dq ? 0 : lo + 1;
      if (pt < 99999) pt++;
      if (!dq && dq_q && !pull) st = 0;
      rd = n >= nw;
      o = ~crc ^ {15'h0000, corrupt};
      pull <= (pt >= S && pt < 5 * S) ||
         (rd && st >= 0 && st < H && !o[(n - nw) & 15]);
      if (st >= 0) st++;
      if (st == S) begin
         st = -1;
         if (!rd) sh = {dq, sh[31:1]};
         n++;
         if (n == 32 && nw == 32) begin
            ta_rx = sh[23:16];
            adr = {5'h00, sh[18:8]};
            crc = crc_byte(CRC_INIT, sh[7:0]);
            crc = crc_byte(crc, adr[7:0]);
            crc = crc_byte(crc, adr[15:8]);
            crc = crc_byte(crc, sh[31:24]);
         end else if (n == 8 && nw == 8) crc = crc_byte(adr, sh[31:24]);
         if (n == nw + 16) begin
            n = 0;
            nw = 8;
            adr++;
         end
      end
      dq_q = dq;
   end
endmodule

// ---- swe_master.sv ----
// single-wire bus master driving the write-memory / write-status flow
// assumes: open-drain line resolved outside, programming supply switched by
// PROG_EN, request held stable while REQ_VALID is high and REQ_READY low
//
// What this block does
// - the master compares the crc itself and skips the pulse when it differs.
// - under a low pull-up voltage the master sends the top five high-address bits as ones.
// - after a reset the line stays high at least 480 us before anything else.
// - the master samples each read bit late but before 15 us after its edge.
// - only a reset request drives a line-low reset of 480 us, then a release; other requests start straight with a slot.
// - after a good crc the master applies 480 us of programming voltage, then idles.
`timescale 1ns/100ps
module swe_master
   import swe_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RESET_N,
   // request and answer
   input wire logic REQ_VALID,
   input wire swe_req_t REQ,
   output logic REQ_READY,
   output logic RSP_VALID,
   output swe_rsp_t RSP,
   // line
   input wire logic DQ_I,
   output logic DQ_O,
   output logic DQ_OE,
   output logic PROG_EN
);
   // =====================================================================
   // state
   typedef enum logic [3:0] {
      SWE_IDLE = 4'h0,
      SWE_RST_LOW = 4'h1,
      SWE_RST_WAIT = 4'h2,
      SWE_RST_HIGH = 4'h3,
      SWE_SLOT = 4'h4,
      SWE_NEXT = 4'h5,
      SWE_DPROG = 4'h6,
      SWE_PROG = 4'h7,
      SWE_DONE = 4'h8
   } swe_state_t;
   typedef struct packed {
      swe_state_t st;
      logic [TW-1:0] cnt;
      logic [2:0] bitn;
      logic [2:0] byten;
      logic [2:0] nbytes;
      logic [39:0] txq;
      logic wr_phase;
      logic [7:0] rx;
      logic [15:0] crc_rx;
      logic [15:0] crc;
      logic [15:0] addr;
      swe_op_t op;
      logic presence;
      logic programmed;
      logic sample;
      logic rsp_valid;
      swe_rsp_t rsp;
   } swe_regs_t;
   swe_regs_t s_r, s_nxt;
   logic rst_s1_r, rst_s2_r;
   logic [15:0] crc_step;
   logic [7:0] crc_byte;
   logic [7:0] ta_hi;
   logic [15:0] next_addr;

   // =====================================================================
   // reset release
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   // =====================================================================
   // crc
   swe_crc16 u_crc (
      .crc_in(s_r.crc),
      .data_in(crc_byte),
      .crc_out(crc_step)
   );
   // the device zeroes the forced high-address bits before its crc
   assign crc_byte = (s_r.op == SWE_OP_WRITE_FIRST && s_r.byten == 3'h2) ?
                     (s_r.txq[7:0] & TA_HIGH_KEEP) : s_r.txq[7:0];
   // low-voltage requests send ones, the device zeroes them back
   assign ta_hi = REQ.low_vpup ? (REQ.addr[15:8] | TA_HIGH_FORCE) :
                  REQ.addr[15:8];
   assign next_addr = s_r.addr + 16'h0001;

   // =====================================================================
   // outputs
   assign REQ_READY = (s_r.st == SWE_IDLE);
   assign RSP_VALID = s_r.rsp_valid;
   assign RSP = s_r.rsp;
   assign DQ_O = 1'b0;
   assign DQ_OE = (s_r.st == SWE_RST_LOW) ||
      ((s_r.st == SWE_SLOT) && (s_r.wr_phase ?
        (s_r.txq[0] ? (s_r.cnt < TW'(C_LOW1)) : (s_r.cnt < TW'(C_LOW0)))
        : (s_r.cnt < TW'(C_LOW1))));
   assign PROG_EN = (s_r.st == SWE_PROG);

   // =====================================================================
   // next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.rsp_valid = 1'b0;
      s_nxt.cnt = s_r.cnt + TW'(1);
      case (s_r.st)
         SWE_IDLE: begin
            s_nxt.cnt = '0;
            if (REQ_VALID) begin
               s_nxt.op = REQ.op;
               s_nxt.programmed = 1'b0;
               s_nxt.bitn = 3'h0;
               s_nxt.byten = 3'h0;
               s_nxt.rx = 8'h00;
               case (REQ.op)
                  SWE_OP_RESET: begin
                     s_nxt.st = SWE_RST_LOW;
                  end
                  SWE_OP_WRITE_FIRST: begin
                     // device crc starts cleared and takes all four bytes
                     s_nxt.crc = CRC_INIT;
                     s_nxt.addr = {ta_hi & TA_HIGH_KEEP, REQ.addr[7:0]};
                     s_nxt.txq = {8'h00, REQ.data, ta_hi, REQ.addr[7:0],
                                  REQ.cmd};
                     s_nxt.nbytes = 3'h4;
                     s_nxt.wr_phase = 1'b1;
                     s_nxt.st = SWE_SLOT;
                  end
                  SWE_OP_WRITE_NEXT: begin
                     s_nxt.addr = next_addr;
                     s_nxt.crc = next_addr;
                     s_nxt.txq = {32'h0, REQ.data};
                     s_nxt.nbytes = 3'h1;
                     s_nxt.wr_phase = 1'b1;
                     s_nxt.st = SWE_SLOT;
                  end
                  SWE_OP_WRITE_BYTE: begin
                     s_nxt.txq = {32'h0, REQ.data};
                     s_nxt.nbytes = 3'h1;
                     s_nxt.wr_phase = 1'b1;
                     s_nxt.st = SWE_SLOT;
                  end
                  default: begin
                     s_nxt.txq = 40'h0;
                     s_nxt.nbytes = 3'h1;
                     s_nxt.wr_phase = 1'b0;
                     s_nxt.st = SWE_SLOT;
                  end
               endcase
            end
         end
         SWE_RST_LOW: begin
            if (s_r.cnt == TW'(C_RESET_LOW - 1)) begin
               s_nxt.cnt = '0;
               s_nxt.st = SWE_RST_WAIT;
            end
         end
         SWE_RST_WAIT: begin
            if (s_r.cnt == TW'(C_PRESENCE_SAMPLE - 1)) begin
               s_nxt.presence = ~DQ_I;
               s_nxt.st = SWE_RST_HIGH;
            end
         end
         SWE_RST_HIGH: begin
            if (s_r.cnt == TW'(C_POST_RESET_HIGH - 1)) begin
               s_nxt.st = SWE_DONE;
            end
         end
         SWE_SLOT: begin
            if (!s_r.wr_phase && s_r.cnt == TW'(C_READ_SAMPLE)) begin
               s_nxt.sample = DQ_I;
            end
            if (s_r.cnt == TW'(C_SLOT + C_RECOVERY - 1)) begin
               s_nxt.cnt = '0;
               s_nxt.st = SWE_NEXT;
            end
         end
         SWE_NEXT: begin
            s_nxt.cnt = '0;
            s_nxt.st = SWE_SLOT;
            if (s_r.wr_phase) begin
               if (s_r.bitn == 3'h0 && s_r.op != SWE_OP_WRITE_BYTE) begin
                  // mirror the device crc once per byte
                  s_nxt.crc = crc_step;
               end
               s_nxt.txq = {1'b0, s_r.txq[39:1]};
               if (s_r.op != SWE_OP_WRITE_BYTE) begin
                  s_nxt.txq = s_r.txq;
                  if (s_r.bitn == 3'h7) begin
                     s_nxt.txq = {8'h00, s_r.txq[39:8]};
                  end else begin
                     s_nxt.txq = {s_r.txq[39:8],
                                  s_r.txq[7:0] >> (s_r.bitn + 3'h1)};
                     s_nxt.txq[7:0] = s_r.txq[7:0] >> 1;
                  end
                  if (s_r.bitn == 3'h0) begin
                     s_nxt.crc = crc_step;
                  end
               end
            end else begin
               s_nxt.rx = {s_r.sample, s_r.rx[7:1]};
               if (s_r.op != SWE_OP_READ_BYTE) begin
                  s_nxt.crc_rx = {s_r.sample, s_r.crc_rx[15:1]};
               end
            end
            s_nxt.bitn = s_r.bitn + 3'h1;
            if (s_r.bitn == 3'h7) begin
               s_nxt.byten = s_r.byten + 3'h1;
               if (s_r.byten + 3'h1 == s_r.nbytes) begin
                  if (s_r.wr_phase && s_r.op != SWE_OP_WRITE_BYTE) begin
                     // crc comes back as two inverted bytes
                     s_nxt.wr_phase = 1'b0;
                     s_nxt.byten = 3'h0;
                     s_nxt.nbytes = 3'h2;
                  end else if (s_r.wr_phase || s_r.op == SWE_OP_READ_BYTE) begin
                     s_nxt.st = SWE_DONE;
                  end else if (~{s_nxt.crc_rx} == s_r.crc) begin
                     s_nxt.cnt = '0;
                     s_nxt.st = SWE_DPROG;
                  end else begin
                     // the device would carry on, so stop here
                     s_nxt.st = SWE_DONE;
                  end
               end
            end
         end
         SWE_DPROG: begin
            // the same idle wait stands before and after the pulse
            if (s_r.cnt == TW'(C_DELAY_PROG - 1)) begin
               s_nxt.cnt = '0;
               if (s_r.programmed) begin
                  s_nxt.st = SWE_DONE;
               end else begin
                  s_nxt.st = SWE_PROG;
               end
            end
         end
         SWE_PROG: begin
            if (s_r.cnt == TW'(C_PROG - 1)) begin
               s_nxt.programmed = 1'b1;
               s_nxt.cnt = '0;
               s_nxt.st = SWE_DPROG;
            end
         end
         SWE_DONE: begin
            s_nxt.rsp_valid = 1'b1;
            s_nxt.rsp.presence = s_r.presence;
            s_nxt.rsp.crc_rx = ~s_r.crc_rx;
            s_nxt.rsp.crc_calc = s_r.crc;
            s_nxt.rsp.crc_ok = (~s_r.crc_rx == s_r.crc);
            s_nxt.rsp.rdata = s_r.rx;
            s_nxt.rsp.programmed = s_r.programmed;
            s_nxt.st = SWE_IDLE;
         end
         default: begin
            s_nxt.st = SWE_IDLE;
         end
      endcase
   end

   // =====================================================================
   // state register; the read slot low is 2 us, inside the 1 to 15 us
   // window; the device needs only the falling edge
   always_ff @(posedge MCLK or negedge rst_s2_r) begin
      if (!rst_s2_r) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// ---- swe_master_assertions.sv ----
// checker on the write-flow master ports, attached by bind
// assumes one clock; RESET_N low disables every property
`timescale 1ns/100ps
module swe_master_assertions
   import swe_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RESET_N,
   // request and answer
   input wire logic REQ_VALID,
   input wire swe_req_t REQ,
   input wire logic REQ_READY,
   input wire logic RSP_VALID,
   input wire swe_rsp_t RSP,
   // line
   input wire logic DQ_I,
   input wire logic DQ_O,
   input wire logic DQ_OE,
   input wire logic PROG_EN
);
   // ======================================================================
   // helper counters; the idle count lo saturates so idle time never wraps
   int hi, lo, pp;
   logic arst, pulsed;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         hi <= 0;
         lo <= 99999;
         pp <= 0;
         arst <= 1'b0;
         pulsed <= 1'b0;
      end else begin
         hi <= DQ_OE ? hi + 1 : 0;
         lo <= DQ_OE ? 0 : (lo < 99999 ? lo + 1 : lo);
         pp <= PROG_EN ? pp + 1 : 0;
         arst <= DQ_OE ? 1'b0 : (arst || hi >= C_RESET_LOW);
         pulsed <= RSP_VALID ? 1'b0 : (pulsed || PROG_EN);
      end
   end
   // ======================================================================
   // properties
   open_drain_a:
      assert property (DQ_O == 1'b0) else $error("line driven high");
   low_width_a:
      assert property (!DQ_OE && hi > 0 |-> hi inside {[CLK_MHZ:15 * CLK_MHZ],
         [60 * CLK_MHZ:120 * CLK_MHZ]} || hi >= C_RESET_LOW)
      else $error("low time out of range");
   post_reset_a:
      assert property ($rose(DQ_OE) && arst |-> lo >= C_POST_RESET_HIGH)
      else $error("reset high time too short");
   recovery_a:
      assert property ($rose(DQ_OE) |-> lo >= CLK_MHZ)
      else $error("recovery too short");
   prog_width_a:
      assert property ($fell(PROG_EN) |-> pp >= C_PROG)
      else $error("program pulse too short");
   prog_release_a:
      assert property (PROG_EN |-> !DQ_OE) else $error("low during pulse");
   idle_after_a:
      assert property ($fell(PROG_EN) |-> !DQ_OE [*8])
      else $error("line not idle after pulse");
   prog_delay_a:
      assert property ($rose(PROG_EN) |-> lo >= C_DELAY_PROG)
      else $error("pulse too soon");
   prog_crc_a:
      assert property (RSP_VALID && RSP.programmed |-> RSP.crc_ok &&
         RSP.crc_rx == RSP.crc_calc) else $error("pulse without crc match");
   prog_decision_a:
      assert property (RSP_VALID |-> pulsed == RSP.programmed)
      else $error("pulse and answer disagree");
endmodule
bind swe_master swe_master_assertions chk (.MCLK(MCLK), .RESET_N(RESET_N),
   .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY),
   .RSP_VALID(RSP_VALID), .RSP(RSP), .DQ_I(DQ_I), .DQ_O(DQ_O),
   .DQ_OE(DQ_OE), .PROG_EN(PROG_EN));

// ---- swe_pkg.sv ----
// constants, types and timing counts for the single-wire write-flow master
// assumes a 100 MHz clock; the line is open drain with an external pull-up
package swe_pkg;
   // =====================================================================
   // clock
   localparam int CLK_MHZ = 100;
   // =====================================================================
   // times in microseconds, as printed
   localparam int T_RESET_LOW_US = 480;
   localparam int T_POST_RESET_HIGH_US = 480;
   localparam int T_PRESENCE_SAMPLE_US = 70;
   localparam int T_SLOT_US = 70;
   localparam int T_LOW1_US = 2;
   localparam int T_LOW0_US = 60;
   localparam int T_READ_SAMPLE_US = 13;
   localparam int T_RECOVERY_US = 2;
   localparam int T_PROG_US = 480;
   localparam int T_DELAY_PROG_US = 5;
   // =====================================================================
   // cycle counts
   localparam int C_RESET_LOW = T_RESET_LOW_US * CLK_MHZ;
   localparam int C_POST_RESET_HIGH = T_POST_RESET_HIGH_US * CLK_MHZ;
   localparam int C_PRESENCE_SAMPLE = T_PRESENCE_SAMPLE_US * CLK_MHZ;
   localparam int C_SLOT = T_SLOT_US * CLK_MHZ;
   localparam int C_LOW1 = T_LOW1_US * CLK_MHZ;
   localparam int C_LOW0 = T_LOW0_US * CLK_MHZ;
   localparam int C_READ_SAMPLE = T_READ_SAMPLE_US * CLK_MHZ;
   localparam int C_RECOVERY = T_RECOVERY_US * CLK_MHZ;
   localparam int C_PROG = T_PROG_US * CLK_MHZ;
   localparam int C_DELAY_PROG = T_DELAY_PROG_US * CLK_MHZ;
   localparam int TW = 17;
   // =====================================================================
   // crc and address
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam logic [7:0] TA_HIGH_FORCE = 8'hF8;
   localparam logic [7:0] TA_HIGH_KEEP = 8'h07;
   // =====================================================================
   // commands given to the master
   typedef enum logic [2:0] {
      SWE_OP_RESET = 3'h0,
      SWE_OP_WRITE_FIRST = 3'h1,
      SWE_OP_WRITE_NEXT = 3'h2,
      SWE_OP_READ_BYTE = 3'h3,
      SWE_OP_WRITE_BYTE = 3'h4
   } swe_op_t;
   typedef struct packed {
      swe_op_t op;
      logic [7:0] cmd;
      logic [15:0] addr;
      logic [7:0] data;
      logic low_vpup;
   } swe_req_t;
   typedef struct packed {
      logic presence;
      logic crc_ok;
      logic [15:0] crc_rx;
      logic [15:0] crc_calc;
      logic [7:0] rdata;
      logic programmed;
   } swe_rsp_t;
endpackage
